// ==== rtl/burst_sram_pkg.sv ====
package burst_sram_pkg;

  localparam int ADDR_W = 19;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int BURST_W = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int DATA_W = LANES * LANE_W;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] bws_n;
  } op_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0] par;
    logic [LANES-1:0] bws_n;
  } wr_s;

  localparam op_s OP_IDLE = '0;
  localparam logic LANES_OE_N_RESET = 1'b1;
  localparam logic SYNC_HIGH_RESET = 1'b1;
  localparam logic SYNC_LOW_RESET = 1'b0;
  localparam logic [BURST_W-1:0] BEAT_RESET = 2'h0;

endpackage

// ==== rtl/write_fifo.sv ====
`timescale 1ns/1ps
module write_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_params
      $error("write_fifo needs a power-of-two depth of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (PTR_W+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = store[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      store[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

// ==== rtl/pipelined_burst_sram_port.sv ====
// Functional notes
// - Write strobe sampled only on gated edges.
// - Advance high steps the burst counter.
// - Advance low loads a new start address.
// - Gate high masks edges, pipeline registers hold.
// - Selected only when all three selects active.
// - Output drive high three-states the lanes.
// - Three-state on write data, deselect, emerging.
// - Gate high stretches, never deselects.
// - Read data from earlier captured address.
// - Write data captured on a rising edge.
// - Eight-bit data lanes, one paired parity bit.
// - Parity written only with its byte select.
// - Sleep request idles, contents kept.
// - Burst order high interleaved, low linear.
// - Read starts: gated, selected, strobe high, load.
// - Two-bit burst counter wraps over four words.
// - Masked write data taken two edges later.
// - Direction latched for the whole burst.
`timescale 1ns/1ps
module pipelined_burst_sram_port (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [burst_sram_pkg::ADDR_W-1:0] address,
  input wire logic select_low_a,
  input wire logic select_high,
  input wire logic select_low_b,
  input wire logic write_n,
  input wire logic advance_or_load,
  input wire logic clock_gate_n,
  input wire logic [burst_sram_pkg::LANES-1:0] byte_write_select_n,
  input wire logic [burst_sram_pkg::DATA_W-1:0] data_lane_in,
  input wire logic [burst_sram_pkg::LANES-1:0] parity_lane_in,
  output logic [burst_sram_pkg::DATA_W-1:0] data_lane_out,
  output logic [burst_sram_pkg::LANES-1:0] parity_lane_out,
  output logic lanes_oe_n,
  input wire logic output_drive_n,
  input wire logic sleep_request,
  input wire logic burst_order,
  output logic write_buffer_ready
);

  localparam int AW = burst_sram_pkg::ADDR_W;
  localparam int LN = burst_sram_pkg::LANES;
  localparam int LW = burst_sram_pkg::LANE_W;
  localparam int BW = burst_sram_pkg::BURST_W;
  localparam int WORD_W = LN * (LW + 1);

  function automatic logic [BW-1:0] burst_bits(input logic [BW-1:0] base, input logic [BW-1:0] beat,
                                               input logic interleaved);
    burst_bits = interleaved ? (base ^ beat) : BW'(base + beat);
  endfunction

  logic rst_meta_reg;
  logic rst_n_i;
  logic drive_meta_reg;
  logic drive_n_s;
  logic sleep_meta_reg;
  logic sleep_s;
  logic order_meta_reg;
  logic order_s;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= burst_sram_pkg::SYNC_LOW_RESET;
      rst_n_i <= burst_sram_pkg::SYNC_LOW_RESET;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_i <= rst_meta_reg;
    end
  end

  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_meta_reg <= burst_sram_pkg::SYNC_HIGH_RESET;
      drive_n_s <= burst_sram_pkg::SYNC_HIGH_RESET;
      sleep_meta_reg <= burst_sram_pkg::SYNC_LOW_RESET;
      sleep_s <= burst_sram_pkg::SYNC_LOW_RESET;
      order_meta_reg <= burst_sram_pkg::SYNC_HIGH_RESET;
      order_s <= burst_sram_pkg::SYNC_HIGH_RESET;
    end else begin
      drive_meta_reg <= output_drive_n;
      drive_n_s <= drive_meta_reg;
      sleep_meta_reg <= sleep_request;
      sleep_s <= sleep_meta_reg;
      order_meta_reg <= burst_order;
      order_s <= order_meta_reg;
    end
  end

  logic edge_ok;
  logic selected;
  logic fifo_in_ready;
  logic load_op;
  logic burst_active_reg;
  logic dir_write_reg;
  logic [AW-1:0] base_reg;
  logic [BW-1:0] beat_reg;
  logic [BW-1:0] beat_next;
  burst_sram_pkg::op_s s1_reg;
  burst_sram_pkg::op_s s2_reg;

  assign edge_ok = !clock_gate_n;
  assign selected = !select_low_a && select_high && !select_low_b;
  assign load_op = !advance_or_load && selected && !sleep_s && fifo_in_ready;
  assign beat_next = BW'(beat_reg + 1'b1);

  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      burst_active_reg <= 1'b0;
      dir_write_reg <= 1'b0;
      base_reg <= '0;
      beat_reg <= burst_sram_pkg::BEAT_RESET;
    end else if (edge_ok) begin
      if (advance_or_load) begin
        if (burst_active_reg) begin
          beat_reg <= beat_next;
        end
      end else if (load_op) begin
        burst_active_reg <= 1'b1;
        dir_write_reg <= !write_n;
        base_reg <= address;
        beat_reg <= burst_sram_pkg::BEAT_RESET;
      end else begin
        burst_active_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg <= burst_sram_pkg::OP_IDLE;
    end else if (edge_ok) begin
      if (advance_or_load) begin
        if (burst_active_reg) begin
          s1_reg.valid <= 1'b1;
          s1_reg.write <= dir_write_reg;
          s1_reg.addr <= {base_reg[AW-1:BW], burst_bits(base_reg[BW-1:0], beat_next, order_s)};
          s1_reg.bws_n <= byte_write_select_n;
        end else begin
          s1_reg <= burst_sram_pkg::OP_IDLE;
        end
      end else if (load_op) begin
        s1_reg.valid <= 1'b1;
        s1_reg.write <= !write_n;
        s1_reg.addr <= address;
        s1_reg.bws_n <= byte_write_select_n;
      end else begin
        s1_reg <= burst_sram_pkg::OP_IDLE;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s2_reg <= burst_sram_pkg::OP_IDLE;
    end else if (edge_ok) begin
      s2_reg <= s1_reg;
    end
  end

  logic [WORD_W-1:0] mem [0:(2**AW)-1];
  logic [WORD_W-1:0] rd_word;

  burst_sram_pkg::wr_s push_word;
  burst_sram_pkg::wr_s pop_word;
  logic push_valid;
  logic pop_valid;
  logic pop_ready;

  assign push_valid = edge_ok && s2_reg.valid && s2_reg.write;
  assign push_word.addr = s2_reg.addr;
  assign push_word.data = data_lane_in;
  assign push_word.par = parity_lane_in;
  assign push_word.bws_n = s2_reg.bws_n;
  assign pop_ready = !sleep_s;

  write_fifo #(
    .WIDTH($bits(burst_sram_pkg::wr_s)),
    .DEPTH(burst_sram_pkg::FIFO_DEPTH)
  ) u_write_fifo (
    .clock(clock),
    .rst_n(rst_n_i),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_word)
  );

  always_ff @(posedge clock) begin
    if (pop_valid && pop_ready) begin
      for (int k = 0; k < LN; k++) begin
        if (!pop_word.bws_n[k]) begin
          mem[pop_word.addr][k*(LW+1) +: (LW+1)] <= {pop_word.par[k], pop_word.data[k*LW +: LW]};
        end
      end
    end
  end

  // The write leaving the buffer and the write entering it are merged in, newest last, so a read right after a write sees them.
  always_comb begin
    rd_word = mem[s1_reg.addr];
    for (int k = 0; k < LN; k++) begin
      if (pop_valid && pop_ready && pop_word.addr == s1_reg.addr && !pop_word.bws_n[k]) begin
        rd_word[k*(LW+1) +: (LW+1)] = {pop_word.par[k], pop_word.data[k*LW +: LW]};
      end
      if (push_valid && push_word.addr == s1_reg.addr && !push_word.bws_n[k]) begin
        rd_word[k*(LW+1) +: (LW+1)] = {push_word.par[k], push_word.data[k*LW +: LW]};
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_lane_out <= '0;
      parity_lane_out <= '0;
    end else if (edge_ok && s1_reg.valid && !s1_reg.write) begin
      for (int k = 0; k < LN; k++) begin
        data_lane_out[k*LW +: LW] <= rd_word[k*(LW+1) +: LW];
        parity_lane_out[k] <= rd_word[k*(LW+1) + LW];
      end
    end
  end

  logic read_stage_next;

  assign read_stage_next = edge_ok ? (s1_reg.valid && !s1_reg.write) : (s2_reg.valid && !s2_reg.write);

  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lanes_oe_n <= burst_sram_pkg::LANES_OE_N_RESET;
    end else begin
      lanes_oe_n <= !(read_stage_next && !drive_n_s);
    end
  end

  always_ff @(posedge clock or negedge rst_n_i) begin
    if (!rst_n_i) begin
      write_buffer_ready <= 1'b0;
    end else begin
      write_buffer_ready <= fifo_in_ready;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n_i);

  a_gate_holds_stage: assert property (clock_gate_n |=> $stable(s1_reg) && $stable(beat_reg))
    else $error("stage changed while clock gate high");
  a_load_takes_addr: assert property (edge_ok && load_op |=> s1_reg.valid && s1_reg.addr == $past(address))
    else $error("load did not capture address");
  a_read_start: assert property (edge_ok && load_op && write_n |=> !s1_reg.write)
    else $error("read not started as read");
  a_deselect_idle: assert property (edge_ok && !advance_or_load && !selected |=> !s1_reg.valid)
    else $error("operation started while deselected");
  a_sleep_blocks_op: assert property (sleep_s && edge_ok && !advance_or_load |=> !s1_reg.valid)
    else $error("operation started during sleep");
  a_drive_off: assert property (drive_n_s |=> lanes_oe_n)
    else $error("lanes driven with output drive high");
  a_write_three_state: assert property (edge_ok && s1_reg.valid && s1_reg.write |=> lanes_oe_n)
    else $error("lanes driven in write data phase");
  a_read_drive_on: assert property (edge_ok && s1_reg.valid && !s1_reg.write && !drive_n_s |=> !lanes_oe_n)
    else $error("read data not driven");
  a_dir_kept: assert property (edge_ok && advance_or_load && burst_active_reg |=> s1_reg.write == $past(dir_write_reg))
    else $error("burst direction changed");
  a_linear_step: assert property (edge_ok && advance_or_load && burst_active_reg && !order_s
                                  |=> s1_reg.addr[1:0] == 2'($past(base_reg[1:0]) + $past(beat_next)))
    else $error("linear burst address wrong");
  a_write_push: assert property (edge_ok && s2_reg.valid && s2_reg.write
                                 |-> push_valid && fifo_in_ready && push_word.data == data_lane_in)
    else $error("write data not taken");
  a_interleave_step: assert property (edge_ok && advance_or_load && burst_active_reg && order_s
                                      |=> s1_reg.addr[BW-1:0] == ($past(base_reg[BW-1:0]) ^ $past(beat_next)))
    else $error("interleaved burst address wrong");
  a_upper_fixed: assert property (edge_ok && advance_or_load && burst_active_reg |=> s1_reg.addr[AW-1:BW] == $past(base_reg[AW-1:BW]))
    else $error("burst changed upper address bits");
  a_beat_wraps: assert property (edge_ok && advance_or_load && burst_active_reg && beat_reg == '1 |=> beat_reg == '0)
    else $error("burst counter did not wrap");
  a_advance_idle: assert property (edge_ok && advance_or_load && !burst_active_reg |=> !s1_reg.valid)
    else $error("advance without burst started an operation");
  a_deselect_float: assert property (edge_ok && !s1_reg.valid |=> lanes_oe_n)
    else $error("lanes driven while deselected");
  a_outputs_hold: assert property (clock_gate_n |=> $stable(data_lane_out) && $stable(parity_lane_out))
    else $error("read data changed on a masked edge");
  a_full_refuses: assert property (edge_ok && !advance_or_load && !fifo_in_ready |=> !s1_reg.valid)
    else $error("load accepted with write buffer full");
  a_dir_capture: assert property (edge_ok && load_op |=> dir_write_reg == !$past(write_n))
    else $error("burst direction not captured at load");
  a_load_beat_zero: assert property (edge_ok && load_op |=> beat_reg == '0)
    else $error("burst counter not cleared at load");

  c_read_burst: cover property (edge_ok && load_op && write_n ##1 (edge_ok && advance_or_load)[*3]);
  c_read_after_write: cover property (edge_ok && s1_reg.valid && !s1_reg.write && push_valid && push_word.addr == s1_reg.addr);
  c_write_single: cover property (edge_ok && load_op && !write_n ##1 edge_ok ##1 edge_ok);
  c_gate_stretch: cover property (s1_reg.valid ##1 clock_gate_n[*2] ##1 edge_ok);
  c_buffer_full: cover property (!fifo_in_ready);

endmodule

// ==== tb/sram_controller_model.sv ====
`timescale 1ns/1ps
module sram_controller_model (
  input wire logic clock,
  output logic [18:0] address,
  output logic select_low_a,
  output logic select_high,
  output logic select_low_b,
  output logic write_n,
  output logic advance_or_load,
  output logic clock_gate_n,
  output logic [3:0] byte_write_select_n,
  output logic [31:0] data_lane_in,
  output logic [3:0] parity_lane_in
);
  logic [36:0] cur = '0;
  logic [36:0] stage1 = '0;
  logic [36:0] stage2 = '0;
  initial begin
    {address, advance_or_load, clock_gate_n, byte_write_select_n} = '0;
    write_n = 1'b1;
    {select_low_a, select_high, select_low_b} = 3'h5;
    {parity_lane_in, data_lane_in} = '0;
  end
  // Write data follows its address by two counted edges.
  always @(posedge clock) begin
    if (!clock_gate_n) begin
      stage1 <= cur;
      stage2 <= stage1;
    end
  end
  // Released lanes toggle so that stale data never looks valid.
  always @(negedge clock) begin
    if (stage2[36]) begin
      {parity_lane_in, data_lane_in} <= stage2[35:0];
    end else begin
      {parity_lane_in, data_lane_in} <= ~{parity_lane_in, data_lane_in};
    end
  end
  task automatic issue(input logic [2:0] sel_n, input logic wpin, input logic adv, input logic [18:0] a,
                       input logic [3:0] bws, input logic drv, input logic [35:0] wd, input int gaps);
    repeat (gaps) begin
      @(negedge clock);
      clock_gate_n = 1'b1;
      address = ~a;
      {select_low_a, write_n, advance_or_load} = ~{select_low_a, write_n, advance_or_load};
    end
    @(negedge clock);
    clock_gate_n = 1'b0;
    {select_low_a, select_high, select_low_b} = sel_n ^ 3'h2;
    write_n = ~wpin;
    advance_or_load = adv;
    address = a;
    byte_write_select_n = bws;
    cur = {drv, wd};
  endtask
endmodule

// ==== tb/pipelined_burst_sram_port_tb.sv ====
`timescale 1ns/1ps
module pipelined_burst_sram_port_tb;
  typedef struct packed {
    logic oe_n;
    logic [35:0] val;
  } note_s;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic output_drive_n = 1'b0;
  logic sleep_request = 1'b0;
  logic burst_order = 1'b1;
  logic [18:0] address;
  logic select_low_a, select_high, select_low_b, write_n, advance_or_load, clock_gate_n;
  logic [3:0] byte_write_select_n, parity_lane_in, parity_lane_out;
  logic [31:0] data_lane_in, data_lane_out;
  logic lanes_oe_n, write_buffer_ready;
  logic [35:0] mem_ref [16];
  note_s notes[$];
  note_s nt;
  logic [3:0] base;
  logic [1:0] beat;
  logic dir, active;
  logic sleeping = 1'b0;
  integer seed = 78752;
  int fails = 0;
  int check_count = 0;
  `define CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin fails++; $display("unexpected at %0t: %s", $time, msg); end end
  always #12.5 clock = ~clock;
  sram_controller_model ctl (.clock(clock), .address(address), .select_low_a(select_low_a),
    .select_high(select_high), .select_low_b(select_low_b), .write_n(write_n),
    .advance_or_load(advance_or_load), .clock_gate_n(clock_gate_n), .byte_write_select_n(byte_write_select_n),
    .data_lane_in(data_lane_in), .parity_lane_in(parity_lane_in));
  pipelined_burst_sram_port uut (.clock(clock), .rstn(rstn), .address(address), .select_low_a(select_low_a),
    .select_high(select_high), .select_low_b(select_low_b), .write_n(write_n),
    .advance_or_load(advance_or_load), .clock_gate_n(clock_gate_n), .byte_write_select_n(byte_write_select_n),
    .data_lane_in(data_lane_in), .parity_lane_in(parity_lane_in), .data_lane_out(data_lane_out),
    .parity_lane_out(parity_lane_out), .lanes_oe_n(lanes_oe_n), .output_drive_n(output_drive_n),
    .sleep_request(sleep_request), .burst_order(burst_order), .write_buffer_ready(write_buffer_ready));
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic op(input logic [2:0] sel_n, input logic wr, input logic adv, input logic [3:0] a4,
                    input logic [3:0] bws);
    logic [63:0] r;
    logic [3:0] idx;
    note_s n;
    r = {$random(seed), $random(seed)};
    if (!adv) begin
      base = a4;
      dir = wr;
      active = (sel_n == 3'h0) && !sleeping;
    end
    beat = adv ? beat + 2'h1 : 2'h0;
    idx = {base[3:2], burst_order ? base[1:0] ^ beat : base[1:0] + beat};
    for (int k = 0; k < 4; k++) begin
      if (active && dir && !bws[k]) begin
        mem_ref[idx][8*k+:8] = r[8*k+:8];
        mem_ref[idx][32+k] = r[32+k];
      end
    end
    n.oe_n = !(active && !dir && !output_drive_n);
    n.val = mem_ref[idx];
    ctl.issue(sel_n, adv ? !dir : wr, adv, {15'h0, a4}, bws, active && dir, r[35:0], $unsigned($random(seed)) % 3);
    notes.push_back(n);
  endtask
  task automatic idle(input int n);
    repeat (n) op(3'h7, 1'b0, 1'b0, 4'h0, 4'hF);
  endtask
  task automatic burst(input logic wr, input logic [3:0] a4, input int beats);
    op(3'h0, wr, 1'b0, a4, 4'h0);
    repeat (beats - 1) op(3'h0, wr, 1'b1, 4'h0, 4'($random(seed)));
  endtask
  always @(posedge clock) begin
    if (ctl.clock_gate_n === 1'b0 && notes.size() > 1) begin
      nt = notes.pop_front();
      #1;
      `CHK(lanes_oe_n, nt.oe_n, "lane drive enable")
      `CHK(write_buffer_ready, 1'b1, "write buffer ready")
      if (!nt.oe_n) `CHK({parity_lane_out, data_lane_out}, nt.val, "read data")
    end
  end
  initial begin
    #200000;
    fails++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    rstn = 1'b1;
    repeat (6) @(negedge clock);
    for (int m = 0; m < 2; m++) begin
      burst_order = m[0];
      idle(4);
      for (int i = 0; i < 16; i++) op(3'h0, 1'b1, 1'b0, 4'(i), 4'h0);
      for (int i = 0; i < 8; i++) burst(1'($random(seed)), 4'($random(seed)), 5);
      for (int i = 0; i < 30; i++) op(3'h0, 1'($random(seed)), i > 0 && 1'($random(seed)), 4'($random(seed)),
                                      4'($random(seed)));
      $display("burst order %0d test done", m);
    end
    for (int s = 0; s < 3; s++) begin
      op(3'(1 << s), 1'b0, 1'b0, 4'(s), 4'h0);
      op(3'h0, 1'b0, 1'b0, 4'(s), 4'h0);
      op(3'h7, 1'b0, 1'b1, 4'h0, 4'h0);
    end
    $display("select test done");
    idle(1);
    output_drive_n = 1'b1;
    idle(3);
    burst(1'b0, 4'h6, 3);
    idle(1);
    output_drive_n = 1'b0;
    idle(3);
    $display("output drive test done");
    op(3'h0, 1'b1, 1'b0, 4'h9, 4'h0);
    idle(2);
    sleep_request = 1'b1;
    idle(4);
    sleeping = 1'b1;
    op(3'h0, 1'b1, 1'b0, 4'h9, 4'h0);
    op(3'h0, 1'b0, 1'b0, 4'h9, 4'h0);
    idle(1);
    sleep_request = 1'b0;
    sleeping = 1'b0;
    idle(4);
    op(3'h0, 1'b0, 1'b0, 4'h9, 4'h0);
    idle(3);
    $display("sleep test done");
    repeat (2) @(negedge clock);
    if (notes.size() > 1) fails++;
    end_sim();
  end
endmodule
